// ### rtl/psd_params.svh
`ifndef PSD_PARAMS_SVH
`define PSD_PARAMS_SVH

// Register byte offsets
`define PSD_OFF_TASKS 12'h000
`define PSD_OFF_EVENTS 12'h004
`define PSD_OFF_CTRL 12'h008
`define PSD_OFF_TOP 12'h00C
`define PSD_OFF_LOOP 12'h010
`define PSD_OFF_STATUS 12'h014
`define PSD_OFF_SLOT 12'h020
`define PSD_SLOT_MASK 12'hFE0
`define PSD_SLOT_SEL 4
`define PSD_SLOT_FLD 3:2
`define PSD_FLD_PTR 2'h0
`define PSD_FLD_LEN 2'h1
`define PSD_FLD_REP 2'h2
`define PSD_FLD_DLY 2'h3

// Task bits
`define PSD_TSK_START0 0
`define PSD_TSK_START1 1
`define PSD_TSK_STOP 2
`define PSD_TSK_ADV 3

// Event bits
`define PSD_EV_STARTED0 0
`define PSD_EV_STARTED1 1
`define PSD_EV_END0 2
`define PSD_EV_END1 3
`define PSD_EV_STOPPED 4
`define PSD_EV_PEND 5

// Control and status fields
`define PSD_CTRL_LOAD 1:0
`define PSD_CTRL_MAN 2
`define PSD_CTRL_PRESC 7:4
`define PSD_ST_RUN 0
`define PSD_ST_SLOT 1
`define PSD_ST_TAIL 2
`define PSD_ST_STOPPING 3
`define PSD_ST_FETCH 4
`define PSD_ST_DONE 5

// Load modes and words per group
`define PSD_LOAD_COMMON 2'h0
`define PSD_LOAD_GROUPED 2'h1
`define PSD_LOAD_INDIV 2'h2
`define PSD_LOAD_SHAPE 2'h3
`define PSD_GW_COMMON 3'h1
`define PSD_GW_GROUPED 3'h2
`define PSD_GW_FULL 3'h4
`define PSD_SHAPE_CH 3

// Duty word layout
`define PSD_POL_BIT 15
`define PSD_CMP_FLD 14:0

`define PSD_TOP_RST 15'h03E8
`define PSD_RESP_OKAY 2'h0
`define PSD_RESP_SLVERR 2'h2

`endif

// ### rtl/psd_pkg.sv
package psd_pkg;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } psd_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } psd_axi_rsp_t;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
  } psd_mem_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } psd_mem_rsp_t;

  typedef enum logic [1:0] {
    PSD_DMA_IDLE = 2'b00,
    PSD_DMA_FETCH = 2'b01,
    PSD_DMA_READY = 2'b11
  } psd_dma_t;

  typedef struct packed {
    logic [31:0] ptr;
    logic [15:0] len;
    logic [15:0] rep;
    logic [15:0] dly;
  } psd_slot_t;

  typedef struct packed {
    logic awready, wready, aw_got, w_got;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready, rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    psd_slot_t [1:0] cfg;
    logic [1:0] load;
    logic manual;
    logic [3:0] presc;
    logic [14:0] top_reg;
    logic [15:0] loop_reg;
    logic [5:0] flags;
    logic run, stop_pend, adv_pend, act, tail, chain_done;
    logic [31:0] a_ptr;
    logic [15:0] a_len, a_rep, a_dly, fpos, loops, rep_cnt, dly_cnt;
    psd_dma_t dma;
    logic [1:0] widx;
    logic [3:0][15:0] grp;
    logic p_first, p_last, p_slot;
    logic [3:0] pre;
    logic [14:0] cnt, top;
    logic [3:0][15:0] cmp;
    logic [3:0] pwm;
    logic [5:0] evt;
    logic mem_req;
    logic [31:0] mem_addr;
  } psd_state_t;

endpackage

// ### rtl/psd_top.sv
// Contract
// - Shape-generation mode drives only the first three outputs.
// - Shape mode fetches four words per period; fourth sets period top.
// - Value-repeat N gives a new duty word every N+1 periods.
// - Manual advance ignores repeat and tail delay; each advance loads next.
// - Words are fetched from slot pointer; length counts 16-bit words.
// - Grouped mode uses one word per pair, individual one per channel.
// - Start from idle fetches the first word before generating periods.
// - Started event once first word is fetched and counter runs with it.
// - Repeat count zero plays the started slot once, no chaining.
// - End event when the slot's last word is loaded and executing.
// - After single playback the last duty word keeps being generated.
// - Stop is accepted anytime; the running period completes first.
// - On halt raise stopped event and release outputs to idle level.
// - After stop only a start task resumes, after fetching first word.
// - Slot pointer and length are captured only on that slot's start.
// - Repeat and delay sampled on start and on each applied word.
// - Top register ignored in shape mode, else applied at period end.
// - Mode, decoder, prescaler, repeat count act at once; set while idle. Here the repeat count is copied from the loop register only on a start task.
// - Duty word bit 15 is polarity, bits 14:0 the compare value.
// - Load mode routes words to all channels, pairs, or each channel.
// - An advance task updates compare registers from the next period.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`include "psd_params.svh"

module psd_top
  import psd_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input psd_axi_req_t axi_req,
  output psd_axi_rsp_t axi_rsp,
  output psd_mem_req_t mem_req,
  input psd_mem_rsp_t mem_rsp,
  input logic [3:0] idle_level,
  output logic [3:0] pwm_out,
  output logic [5:0] evt_out
);

  psd_state_t s_q, s_d;
  logic tick, pe;
  logic [32:0] rd_res;
  logic [31:0] wm, wv;
  logic [5:0] clr;
  logic [3:0] tsk;
  logic [2:0] gw;
  logic sl;

  function automatic logic [2:0] grp_words(logic [1:0] ld);
    case (ld)
      `PSD_LOAD_COMMON: return `PSD_GW_COMMON;
      `PSD_LOAD_GROUPED: return `PSD_GW_GROUPED;
      default: return `PSD_GW_FULL;
    endcase
  endfunction

  function automatic logic [32:0] rd_word(psd_state_t x, logic [11:0] a);
    logic [31:0] d;
    logic ok;
    d = '0;
    ok = 1'b1;
    if ((a & `PSD_SLOT_MASK) == `PSD_OFF_SLOT) begin
      case (a[`PSD_SLOT_FLD])
        `PSD_FLD_PTR: d = x.cfg[a[`PSD_SLOT_SEL]].ptr;
        `PSD_FLD_LEN: d[15:0] = x.cfg[a[`PSD_SLOT_SEL]].len;
        `PSD_FLD_REP: d[15:0] = x.cfg[a[`PSD_SLOT_SEL]].rep;
        default: d[15:0] = x.cfg[a[`PSD_SLOT_SEL]].dly;
      endcase
    end else begin
      case (a)
        `PSD_OFF_TASKS: d = '0;
        `PSD_OFF_EVENTS: d[5:0] = x.flags;
        `PSD_OFF_CTRL: begin
          d[`PSD_CTRL_LOAD] = x.load;
          d[`PSD_CTRL_MAN] = x.manual;
          d[`PSD_CTRL_PRESC] = x.presc;
        end
        `PSD_OFF_TOP: d[14:0] = x.top_reg;
        `PSD_OFF_LOOP: d[15:0] = x.loop_reg;
        `PSD_OFF_STATUS: begin
          d[`PSD_ST_RUN] = x.run;
          d[`PSD_ST_SLOT] = x.act;
          d[`PSD_ST_TAIL] = x.tail;
          d[`PSD_ST_STOPPING] = x.stop_pend;
          d[`PSD_ST_FETCH] = (x.dma == PSD_DMA_FETCH);
          d[`PSD_ST_DONE] = x.chain_done;
        end
        default: ok = 1'b0;
      endcase
    end
    return {ok, d};
  endfunction

  // Pointer and length are captured here only; repeat and delay are read again from the slot on each applied word after the first
  function automatic psd_state_t seq_load(psd_state_t x, logic slot);
    x.act = slot;
    x.a_ptr = x.cfg[slot].ptr;
    x.a_len = x.cfg[slot].len;
    x.a_rep = x.cfg[slot].rep;
    x.a_dly = x.cfg[slot].dly;
    x.fpos = '0;
    x.widx = '0;
    x.tail = 1'b0;
    x.chain_done = 1'b0;
    x.dma = PSD_DMA_IDLE;
    return x;
  endfunction

  // Moves the fetched group into the compare registers
  function automatic psd_state_t do_apply(psd_state_t x);
    case (x.load)
      `PSD_LOAD_COMMON: x.cmp = {4{x.grp[0]}};
      `PSD_LOAD_GROUPED: x.cmp = {{2{x.grp[1]}}, {2{x.grp[0]}}};
      `PSD_LOAD_INDIV: x.cmp = x.grp;
      default: begin
        x.cmp = {16'h0000, x.grp[2], x.grp[1], x.grp[0]};
        x.top = x.grp[3][`PSD_CMP_FLD];
      end
    endcase
    if (x.p_first) begin
      x.evt[`PSD_EV_STARTED0 + 32'(x.p_slot)] = 1'b1;
    end
    if (x.p_last) begin
      x.evt[`PSD_EV_END0 + 32'(x.p_slot)] = 1'b1;
    end
    x.rep_cnt = x.p_first ? x.a_rep : x.cfg[x.p_slot].rep;
    x.dly_cnt = x.p_first ? x.a_dly : x.cfg[x.p_slot].dly;
    if (x.manual) begin
      x.rep_cnt = '0;
      x.dly_cnt = '0;
    end
    x.tail = x.p_last;
    x.dma = PSD_DMA_IDLE;
    return x;
  endfunction

  // After slot 0 comes slot 1; each slot 1 end uses one repeat
  function automatic psd_state_t chain(psd_state_t x);
    if (x.loops == '0) begin
      x.chain_done = 1'b1;
    end else if (!x.act) begin
      x = seq_load(x, 1'b1);
    end else if (x.loops == 16'h0001) begin
      x.loops = '0;
      x.chain_done = 1'b1;
    end else begin
      x.loops = x.loops - 16'h0001;
      x = seq_load(x, 1'b0);
    end
    return x;
  endfunction

  assign tick = s_q.run && (s_q.pre == s_q.presc);
  assign pe = tick && ({1'b0, s_q.cnt} + 16'h0001 >= {1'b0, s_q.top});

  always_comb begin
    s_d = s_q;
    s_d.evt = '0;
    clr = '0;
    tsk = '0;
    wv = '0;
    sl = 1'b0;
    gw = grp_words(s_q.load);
    rd_res = rd_word(s_q, s_q.aw_addr);
    for (int b = 0; b < 4; b++) begin
      wm[b * 8 +: 8] = {8{s_q.w_strb[b]}};
    end
    // Bus write side
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end
    if (axi_req.awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.w_data = axi_req.wdata;
      s_d.w_strb = axi_req.wstrb;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = rd_res[32] ? `PSD_RESP_OKAY : `PSD_RESP_SLVERR;
      wv = (rd_res[31:0] & ~wm) | (s_q.w_data & wm);
      sl = s_q.aw_addr[`PSD_SLOT_SEL];
      if ((s_q.aw_addr & `PSD_SLOT_MASK) == `PSD_OFF_SLOT) begin
        case (s_q.aw_addr[`PSD_SLOT_FLD])
          `PSD_FLD_PTR: s_d.cfg[sl].ptr = wv;
          `PSD_FLD_LEN: s_d.cfg[sl].len = wv[15:0];
          `PSD_FLD_REP: s_d.cfg[sl].rep = wv[15:0];
          default: s_d.cfg[sl].dly = wv[15:0];
        endcase
      end else begin
        case (s_q.aw_addr)
          `PSD_OFF_TASKS: tsk = s_q.w_data[3:0] & wm[3:0];
          `PSD_OFF_EVENTS: clr = s_q.w_data[5:0] & wm[5:0];
          `PSD_OFF_CTRL: begin
            s_d.load = wv[`PSD_CTRL_LOAD];
            s_d.manual = wv[`PSD_CTRL_MAN];
            s_d.presc = wv[`PSD_CTRL_PRESC];
          end
          `PSD_OFF_TOP: s_d.top_reg = wv[14:0];
          `PSD_OFF_LOOP: s_d.loop_reg = wv[15:0];
          default: ;
        endcase
      end
    end
    // Bus read side
    if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s_q.arready) begin
      {s_d.rresp[0], s_d.rdata} = rd_word(s_q, axi_req.araddr);
      s_d.rresp = s_d.rresp[0] ? `PSD_RESP_OKAY : `PSD_RESP_SLVERR;
      s_d.rvalid = 1'b1;
    end
    // Reader of duty words
    case (s_q.dma)
      PSD_DMA_IDLE: begin
        if (!s_q.tail && s_q.fpos < s_q.a_len) begin
          s_d.dma = PSD_DMA_FETCH;
          s_d.widx = '0;
        end
      end
      PSD_DMA_FETCH: begin
        if (mem_rsp.ack) begin
          s_d.grp[s_q.widx] = mem_rsp.rdata;
          if ({1'b0, s_q.widx} == gw - 3'h1) begin
            s_d.dma = PSD_DMA_READY;
            s_d.p_first = (s_q.fpos == '0);
            s_d.p_last = ({1'b0, s_q.fpos} + 17'(gw) >= {1'b0, s_q.a_len});
            s_d.p_slot = s_q.act;
            s_d.fpos = s_q.fpos + 16'(gw);
            s_d.widx = '0;
          end else begin
            s_d.widx = s_q.widx + 2'h1;
          end
        end
      end
      PSD_DMA_READY: ;
      default: s_d.dma = PSD_DMA_IDLE;
    endcase
    // Wave counter
    if (s_q.run) begin
      s_d.pre = tick ? '0 : s_q.pre + 4'h1;
    end
    if (tick) begin
      s_d.cnt = pe ? '0 : s_q.cnt + 15'h0001;
    end
    if (!s_q.run && s_q.dma == PSD_DMA_READY) begin
      s_d = do_apply(s_d);
      if (s_q.load != `PSD_LOAD_SHAPE) begin
        s_d.top = s_q.top_reg;
      end
      s_d.run = 1'b1;
      s_d.cnt = '0;
      s_d.pre = '0;
    end
    if (pe) begin
      s_d.evt[`PSD_EV_PEND] = 1'b1;
      if (s_q.load != `PSD_LOAD_SHAPE) begin
        s_d.top = s_q.top_reg;
      end
      if (s_q.stop_pend) begin
        s_d.run = 1'b0;
        s_d.stop_pend = 1'b0;
        s_d.adv_pend = 1'b0;
        s_d.evt[`PSD_EV_STOPPED] = 1'b1;
      end else if (s_q.manual) begin
        if (s_q.adv_pend && s_q.dma == PSD_DMA_READY) begin
          s_d = do_apply(s_d);
          s_d.adv_pend = 1'b0;
        end else if (s_q.adv_pend && s_q.tail && !s_q.chain_done) begin
          s_d = chain(s_d);
          s_d.adv_pend = 1'b0;
        end
      end else if (s_q.rep_cnt != '0) begin
        s_d.rep_cnt = s_q.rep_cnt - 16'h0001;
      end else if (s_q.tail) begin
        if (s_q.dly_cnt != '0) begin
          s_d.dly_cnt = s_q.dly_cnt - 16'h0001;
        end else if (!s_q.chain_done) begin
          s_d = chain(s_d);
        end
      end else if (s_q.dma == PSD_DMA_READY) begin
        s_d = do_apply(s_d);
      end
    end
    // Tasks
    if (tsk[`PSD_TSK_START0] || tsk[`PSD_TSK_START1]) begin
      s_d = seq_load(s_d, !tsk[`PSD_TSK_START0]);
      s_d.loops = s_q.loop_reg;
    end else if (tsk[`PSD_TSK_STOP]) begin
      s_d.tail = 1'b1;
      s_d.chain_done = 1'b1;
      s_d.dma = PSD_DMA_IDLE;
      if (s_q.run) begin
        s_d.stop_pend = 1'b1;
      end else begin
        s_d.evt[`PSD_EV_STOPPED] = 1'b1;
      end
    end
    if (tsk[`PSD_TSK_ADV] && s_q.manual) begin
      s_d.adv_pend = 1'b1;
    end
    s_d.flags = (s_q.flags & ~clr) | s_d.evt;
    // Registered outputs
    s_d.mem_req = (s_d.dma == PSD_DMA_FETCH);
    s_d.mem_addr = s_d.a_ptr
      + {15'h0000, s_d.fpos + {14'h0000, s_d.widx}, 1'b0};
    for (int i = 0; i < 4; i++) begin
      if (!s_d.run || (i == `PSD_SHAPE_CH && s_d.load == `PSD_LOAD_SHAPE)) begin
        s_d.pwm[i] = idle_level[i];
      end else if (s_d.cnt < s_d.cmp[i][`PSD_CMP_FLD]) begin
        s_d.pwm[i] = s_d.cmp[i][`PSD_POL_BIT];
      end else begin
        s_d.pwm[i] = ~s_d.cmp[i][`PSD_POL_BIT];
      end
    end
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.top_reg <= `PSD_TOP_RST;
      s_q.top <= `PSD_TOP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign axi_rsp = '{awready: s_q.awready, wready: s_q.wready,
                     bvalid: s_q.bvalid, bresp: s_q.bresp,
                     arready: s_q.arready, rvalid: s_q.rvalid,
                     rdata: s_q.rdata, rresp: s_q.rresp};
  assign mem_req = '{req: s_q.mem_req, addr: s_q.mem_addr};
  assign pwm_out = s_q.pwm;
  assign evt_out = s_q.evt;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence sq_stop_at_end;
    s_q.stop_pend && pe;
  endsequence

  sequence sq_halted;
    !s_q.run && evt_out[`PSD_EV_STOPPED];
  endsequence

  a_shape_ch3_idle: assert property (
    s_q.load == `PSD_LOAD_SHAPE |-> pwm_out[3] == $past(idle_level[3]))
    else $error("fourth output driven in shape mode");
  a_shape_four_words: assert property (
    (s_q.load == `PSD_LOAD_SHAPE && s_q.dma == PSD_DMA_FETCH
     && mem_rsp.ack && s_q.widx != 2'h3 && tsk == '0)
    |=> s_q.dma == PSD_DMA_FETCH)
    else $error("shape group ended before four words");
  a_repeat_hold: assert property (
    (pe && !s_q.manual && !s_q.stop_pend && s_q.rep_cnt != '0)
    |=> s_q.cmp == $past(s_q.cmp) && s_q.rep_cnt == $past(s_q.rep_cnt) - 1)
    else $error("duty changed inside repeat interval");
  a_manual_wait: assert property (
    (pe && s_q.manual && !s_q.adv_pend) |=> s_q.cmp == $past(s_q.cmp))
    else $error("manual mode loaded without advance");
  a_fetch_window: assert property (
    s_q.mem_req |-> (s_q.mem_addr - s_q.a_ptr) < {s_q.a_len, 1'b0})
    else $error("fetch outside slot buffer");
  a_first_fetch: assert property (
    $rose(s_q.run) |-> $past(s_q.dma) == PSD_DMA_READY)
    else $error("generation began before first word");
  a_started_pulse: assert property (
    $rose(s_q.run) |-> |evt_out[`PSD_EV_STARTED1:`PSD_EV_STARTED0])
    else $error("no started event at start");
  a_single_play: assert property (
    (pe && s_q.tail && s_q.loops == '0 && s_q.rep_cnt == '0
     && s_q.dly_cnt == '0 && !s_q.manual && !s_q.stop_pend
     && !s_q.chain_done && tsk == '0)
    |=> s_q.chain_done && s_q.act == $past(s_q.act))
    else $error("single playback chained");
  a_hold_last: assert property (
    s_q.chain_done |=> s_q.cmp == $past(s_q.cmp))
    else $error("duty changed after playback end");
  a_stop_halt: assert property (
    sq_stop_at_end |=> sq_halted)
    else $error("stop did not halt at period end");
  a_idle_release: assert property (
    $fell(s_q.run) |-> pwm_out == $past(idle_level))
    else $error("outputs not idle after halt");
  a_start_latch: assert property (
    tsk[`PSD_TSK_START0] |=> s_q.a_ptr == $past(s_q.cfg[0].ptr)
    && s_q.a_len == $past(s_q.cfg[0].len))
    else $error("pointer not captured on start");
  a_top_reload: assert property (
    (pe && s_q.load != `PSD_LOAD_SHAPE) |=> s_q.top == $past(s_q.top_reg))
    else $error("top not applied at period end");
  a_sticky_flag: assert property (
    (|evt_out) |-> (s_q.flags & evt_out) == evt_out)
    else $error("event without sticky flag");

endmodule

// ### testbench/psd_mem_model.sv
module psd_mem_model
  import psd_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input psd_mem_req_t mem_req,
  output psd_mem_rsp_t mem_rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] ram_base = 32'h2000_0000;

  logic [15:0] ram [0:255];
  logic [15:0] word;
  int wait_q = 0;

  // Only the RAM window holds data; anything else returns a marker
  assign word = (mem_req.addr[31:9] == ram_base[31:9]) ?
    ram[mem_req.addr[8:1]] : 16'hDEAD;

  // Released data lines toggle so a stale word is never mistaken for valid
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_rsp <= '0;
    end else if (mem_rsp.ack || !mem_req.req || wait_q > 0) begin
      mem_rsp.ack <= 1'b0;
      mem_rsp.rdata <= ~mem_rsp.rdata;
      if (wait_q > 0 && !mem_rsp.ack) wait_q <= wait_q - 1;
    end else begin
      mem_rsp.ack <= 1'b1;
      mem_rsp.rdata <= word;
      wait_q <= $urandom_range(3, 0);
    end
  end
endmodule

// ### testbench/tb.sv
`include "psd_params.svh"

module tb
  import psd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  psd_axi_req_t axi_req = '0;
  psd_axi_rsp_t axi_rsp;
  psd_mem_req_t mem_req;
  psd_mem_rsp_t mem_rsp;
  logic [3:0] idle_level = 4'h0;
  logic [3:0] pwm_out;
  logic [5:0] evt_out;
  logic [5:0] ev_prev = 6'h00;
  logic [31:0] exp_addr = 32'h0000_0000;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [15:0] words [0:15];
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_fetch = 0;
  int last_p = 0;
  int n_ev [6] = '{default: 0};
  int t_ev [6] = '{default: 0};

  always #2.5 aclk = ~aclk;

  psd_top dut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .mem_req(mem_req), .mem_rsp(mem_rsp),
    .idle_level(idle_level), .pwm_out(pwm_out), .evt_out(evt_out));
  psd_mem_model mem (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req),
    .mem_rsp(mem_rsp));

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  task automatic give_up(input string what);
    fails++;
    $display("unexpected %s: expected done seen timeout", what);
    summarize();
  endtask

  // Event and fetch monitor, sampled at each rising edge
  always @(posedge aclk) begin
    cyc++;
    if (aresetn) begin
      for (int b = 0; b < 6; b++) begin
        if (evt_out[b] === 1'b1) begin
          n_ev[b]++;
          t_ev[b] = cyc;
        end
      end
      chk("event overlap", 32'h0, 32'(evt_out & ev_prev));
      if (mem_req.req && mem_rsp.ack) begin
        chk("fetch address", exp_addr, mem_req.addr);
        exp_addr += 2;
        n_fetch++;
      end
    end
    ev_prev = evt_out;
  end

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid) begin
        axi_req.bready <= 1'b0;
        r = axi_rsp.bresp;
        return;
      end
    end
    give_up("write response");
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid) begin
        axi_req.rready <= 1'b0;
        d = axi_rsp.rdata;
        r = axi_rsp.rresp;
        return;
      end
    end
    give_up("read response");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    axi_wr(a, d, rsp);
    chk("write response", 32'(`PSD_RESP_OKAY), 32'(rsp));
  endtask

  task automatic wait_ev(input int b, input int n0, input int bound);
    for (int k = 0; k < bound && n_ev[b] == n0; k++) @(negedge aclk);
    if (n_ev[b] == n0) give_up("event wait");
  endtask

  task automatic stop_gen();
    int n0;
    n0 = n_ev[4];
    wr(`PSD_OFF_TASKS, 32'h0000_0004);
    wait_ev(4, n0, last_p + 20);
    repeat (4) begin
      @(negedge aclk);
      chk("idle output", 32'(idle_level), 32'(pwm_out));
      chk("fetch when stopped", 32'h0, 32'(mem_req.req));
    end
  endtask

  // Word driving channel c in the last group of a sequence
  function automatic logic [15:0] word_of(input int ld, input int base,
                                          input int c);
    return words[base + ((ld == 0) ? 0 : (ld == 1) ? c / 2 : c)];
  endfunction

  task automatic run_seq(input int ld, input int len, input bit man,
                         input bit abort);
    int gw, g, rep, presc, top, p, pp, slot, ex, ne0, no0, nf0;
    bit seen;
    int on [4];
    logic [31:0] ptr;
    logic [11:0] sb;
    logic [15:0] ew;
    gw = (ld == 0) ? 1 : (ld == 1) ? 2 : 4;
    g = len / gw;
    rep = abort ? 2 : $urandom_range(2, 0);
    presc = $urandom_range(1, 0);
    top = $urandom_range(50, 30);
    p = top * (presc + 1);
    slot = $urandom_range(1, 0);
    sb = `PSD_OFF_SLOT + 12'(16 * slot);
    ptr = 32'h2000_0000 + 32'(2 * $urandom_range(64, 0));
    idle_level <= 4'($urandom);
    stop_gen();
    for (int i = 0; i < len; i++) begin
      words[i] = {1'($urandom), 15'($urandom_range(top, 0))};
      if (ld == 3 && i % 4 == 3) words[i] = {1'b0, 15'($urandom_range(50, 30))};
      mem.ram[ptr[8:1] + i] = words[i];
    end
    wr(`PSD_OFF_CTRL, {24'h00_0000, 4'(presc), 1'b0, man, 2'(ld)});
    wr(`PSD_OFF_TOP, 32'(top));
    wr(`PSD_OFF_LOOP, 32'h0000_0000);
    wr(sb, ptr);
    wr(sb + 12'h004, 32'(len));
    wr(sb + 12'h008, 32'(rep));
    wr(sb + 12'h00C, 32'h0000_0000);
    wr(`PSD_OFF_EVENTS, 32'h0000_003F);
    ne0 = n_ev[slot + 2];
    no0 = n_ev[1 - slot];
    nf0 = n_fetch;
    exp_addr = ptr;
    wr(`PSD_OFF_TASKS, 32'(1 << slot));
    seen = 1'b0;
    for (int k = 0; k < 400 && !seen; k++) begin
      @(negedge aclk);
      seen = evt_out[slot] === 1'b1;
      if (!seen) chk("early output", 32'(idle_level), 32'(pwm_out));
    end
    if (!seen) give_up("sequence start");
    last_p = ((ld == 3) ? 50 : top) * (presc + 1);
    if (abort) begin
      stop_gen();
      repeat (3 * p) @(negedge aclk);
      chk("end after stop", 32'(ne0), 32'(n_ev[slot + 2]));
      return;
    end
    if (man) begin
      repeat ((rep + 2) * p * g) @(negedge aclk);
      chk("end unadvanced", 32'(ne0), 32'(n_ev[slot + 2]));
      for (int i = 1; i < g; i++) begin
        wr(`PSD_OFF_TASKS, 32'h0000_0008);
        repeat (2 * p) @(negedge aclk);
      end
      chk("end advanced", 32'(ne0 + 1), 32'(n_ev[slot + 2]));
    end else begin
      wait_ev(slot + 2, ne0, 2000);
      ex = 0;
      for (int i = 0; i < g - 1; i++) begin
        ex += (rep + 1) * ((ld == 3) ?
          int'(words[4 * i + 3][14:0]) * (presc + 1) : p);
      end
      chk("end spacing", 32'(ex), 32'(t_ev[slot + 2] - t_ev[slot]));
    end
    chk("words fetched", 32'(len), 32'(n_fetch - nf0));
    chk("other slot", 32'(no0), 32'(n_ev[1 - slot]));
    pp = (ld == 3) ? int'(words[len - 1][14:0]) * (presc + 1) : p;
    on = '{default: 0};
    repeat (2) @(negedge aclk);
    repeat (pp) begin
      @(negedge aclk);
      for (int c = 0; c < 4; c++) begin
        ew = word_of(ld, len - gw, c);
        if (pwm_out[c] === ew[15]) on[c]++;
      end
    end
    for (int c = 0; c < ((ld == 3) ? 3 : 4); c++) begin
      ew = word_of(ld, len - gw, c);
      ex = (int'(ew[14:0]) < pp / (presc + 1)) ? int'(ew[14:0]) * (presc + 1) : pp;
      chk("channel duty", 32'(ex), 32'(on[c]));
    end
    axi_rd(`PSD_OFF_EVENTS, rd, rsp);
    chk("event flags", slot ? 32'h0000_002A : 32'h0000_0025,
        rd & 32'h0000_003F);
    wr(`PSD_OFF_EVENTS, 32'h0000_001F);
    axi_rd(`PSD_OFF_EVENTS, rd, rsp);
    chk("flags cleared", 32'h0, rd & 32'h0000_001F);
  endtask

  initial begin
    int ld;
    void'($urandom(80428));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(`PSD_OFF_TOP, rd, rsp);
    chk("top after reset", 32'(`PSD_TOP_RST), rd);
    axi_rd(`PSD_OFF_CTRL, rd, rsp);
    chk("control after reset", 32'h0, rd);
    axi_rd(12'h0FC, rd, rsp);
    chk("unmapped read", 32'(`PSD_RESP_SLVERR), 32'(rsp));
    axi_wr(12'h0FC, 32'hFFFF_FFFF, rsp);
    chk("unmapped write", 32'(`PSD_RESP_SLVERR), 32'(rsp));
    run_seq(0, 3, 1'b0, 1'b0);
    run_seq(1, 4, 1'b0, 1'b0);
    run_seq(2, 8, 1'b0, 1'b0);
    run_seq(3, 8, 1'b0, 1'b0);
    run_seq(0, 4, 1'b1, 1'b0);
    run_seq(2, 8, 1'b0, 1'b1);
    repeat (4) begin
      ld = $urandom_range(3, 0);
      run_seq(ld, (ld == 0 ? 1 : ld == 1 ? 2 : 4) * $urandom_range(3, 1),
              1'b0, 1'b0);
    end
    summarize();
  end
endmodule
